//--- design/uadr_pkg.sv
package uadr_pkg;
    localparam int unsigned SAMPLES_NORMAL = 16;
    localparam int unsigned SAMPLES_DOUBLE = 8;
    localparam logic [3:0] FIRST_VOTE_NORMAL = 4'h8;
    localparam logic [3:0] FIRST_VOTE_DOUBLE = 4'h4;
    localparam logic [3:0] BITS_MIN = 4'h5;
    localparam logic [3:0] BITS_MAX = 4'ha;
    localparam int unsigned WORD_WIDTH = 10;
    localparam logic [15:0] DIVISOR_RESET = 16'h0000;
    typedef enum {UADR_IDLE, UADR_START, UADR_BITS, UADR_STOP} uadr_state_t;
endpackage

//--- design/uadr_stream_if.sv
`timescale 1ns/100ps
interface uadr_stream_if #(parameter int W = 11);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

//--- design/uadr_buffer.sv
`timescale 1ns/100ps
module uadr_buffer #(
    parameter int W = 11,
    parameter int DEPTH = 2
) (
    input wire logic clock,
    input wire logic rst_n,
    uadr_stream_if.sink in_s,
    uadr_stream_if.source out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_s.ready = (count != (AW+1)'(DEPTH));
    assign out_s.valid = (count != '0);
    assign out_s.data = mem[rd_ptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_s.data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

//--- design/uadr_rx.sv
`timescale 1ns/100ps
module uadr_rx
    import uadr_pkg::*;
#(
    parameter int unsigned DIV_WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rx_line,
    input wire logic double_speed_select,
    input wire logic [DIV_WIDTH-1:0] baud_divisor,
    input wire logic [3:0] data_bits,
    output logic [uadr_pkg::WORD_WIDTH-1:0] rx_data,
    output logic frame_error_flag,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic rx_overrun,
    output logic busy
);
    import uadr_pkg::*;

    // ****************************************
    // Sample tick
    // ****************************************
    // One tick per sample; divisor N gives N+1 clocks per sample
    logic [DIV_WIDTH-1:0] div_cnt;
    logic tick;
    logic rx_prev;
    logic [3:0] sample;
    logic [2:0] votes;
    logic [3:0] bit_cnt;
    logic [WORD_WIDTH-1:0] shift;
    logic [3:0] frame_bits;
    uadr_state_t state;

    logic [3:0] first_vote;
    logic [3:0] last_sample;
    logic vote;
    logic falling;
    logic in_window;
    logic last_vote;
    logic bit_end;

    assign tick = (div_cnt == '0);
    assign first_vote = double_speed_select ? FIRST_VOTE_DOUBLE : FIRST_VOTE_NORMAL;
    assign last_sample = double_speed_select ? 4'(SAMPLES_DOUBLE - 1) : 4'(SAMPLES_NORMAL - 1);
    assign in_window = (sample >= first_vote) && (sample <= first_vote + 4'h2);
    assign last_vote = tick && (sample == first_vote + 4'h2);
    assign bit_end = tick && (sample == last_sample);
    // Votes so far plus the current third sample
    assign vote = (votes[1] & votes[0]) | (votes[1] & rx_line) | (votes[0] & rx_line);
    assign falling = rx_prev && !rx_line;

    // Clamp length so a bad setting cannot run past the shift register
    always_comb begin
        if (data_bits < BITS_MIN) begin
            frame_bits = BITS_MIN;
        end else if (data_bits > BITS_MAX) begin
            frame_bits = BITS_MAX;
        end else begin
            frame_bits = data_bits;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= DIVISOR_RESET;
        end else if (state == UADR_IDLE && falling) begin
            div_cnt <= baud_divisor;
        end else if (tick) begin
            div_cnt <= baud_divisor;
        end else begin
            div_cnt <= div_cnt - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_line;
        end
    end

    // ****************************************
    // Recovery state machine
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= UADR_IDLE;
            sample <= 4'h0;
            bit_cnt <= 4'h0;
            votes <= 3'h0;
        end else begin
            case (state)
                UADR_IDLE: begin
                    if (falling) begin
                        state <= UADR_START;
                        sample <= 4'h1;
                        votes <= 3'h0;
                    end
                end
                UADR_START: begin
                    if (tick) begin
                        if (in_window) begin
                            votes <= {votes[1:0], rx_line};
                        end
                        if (last_vote && vote) begin
                            state <= UADR_IDLE;
                        end else if (bit_end) begin
                            state <= UADR_BITS;
                            sample <= 4'h0;
                            bit_cnt <= 4'h0;
                        end else begin
                            sample <= sample + 4'h1;
                        end
                    end
                end
                UADR_BITS: begin
                    if (tick) begin
                        if (in_window) begin
                            votes <= {votes[1:0], rx_line};
                        end
                        if (bit_end) begin
                            sample <= 4'h0;
                            if (bit_cnt == frame_bits - 4'h1) begin
                                state <= UADR_STOP;
                            end else begin
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end else begin
                            sample <= sample + 4'h1;
                        end
                    end
                end
                UADR_STOP: begin
                    if (tick) begin
                        if (in_window) begin
                            votes <= {votes[1:0], rx_line};
                        end
                        sample <= sample + 4'h1;
                        // Rest of stop bit and later stop bits are not looked at
                        if (last_vote) begin
                            state <= UADR_IDLE;
                        end
                    end
                end
                default: begin
                    state <= UADR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift <= '0;
        end else if (state == UADR_START) begin
            shift <= '0;
        end else if (state == UADR_BITS && last_vote) begin
            shift[bit_cnt] <= vote;
        end
    end

    // ****************************************
    // Output buffer
    // ****************************************
    // Two entries so a stalled reader still holds the frame that just closed
    uadr_stream_if #(.W(WORD_WIDTH + 1)) fill_s ();
    uadr_stream_if #(.W(WORD_WIDTH + 1)) drain_s ();

    assign fill_s.valid = (state == UADR_STOP) && last_vote;
    assign fill_s.data = {!vote, shift};
    // Pop only when the output register loads, so each word leaves exactly once
    assign drain_s.ready = !rx_valid || rx_ready;

    uadr_buffer #(.W(WORD_WIDTH + 1), .DEPTH(2)) u_buffer (
        .clock(clock),
        .rst_n(rst_n),
        .in_s(fill_s.sink),
        .out_s(drain_s.source)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= '0;
            frame_error_flag <= 1'b0;
            rx_valid <= 1'b0;
        end else if (!rx_valid || rx_ready) begin
            rx_valid <= drain_s.valid;
            if (drain_s.valid) begin
                rx_data <= drain_s.data[WORD_WIDTH-1:0];
                frame_error_flag <= drain_s.data[WORD_WIDTH];
            end
        end
    end

    // Frame dropped when both buffer entries are taken
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_overrun <= 1'b0;
        end else begin
            rx_overrun <= fill_s.valid && !fill_s.ready;
        end
    end

    assign busy = (state != UADR_IDLE);
endmodule

//--- verif/uadr_rx_asserts.sv
`timescale 1ns/100ps
module uadr_rx_asserts
    import uadr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic rx_line,
    input wire logic double_speed_select,
    input wire logic [15:0] baud_divisor,
    input wire logic [3:0] data_bits,
    input wire logic [uadr_pkg::WORD_WIDTH-1:0] rx_data,
    input wire logic frame_error_flag,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_overrun,
    input wire logic busy
);
    logic [15:0] busy_len;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ****
    // Cycles away from idle
    // ****
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) busy_len <= 16'h0;
        else busy_len <= busy ? busy_len + 16'h1 : 16'h0;
    end
    // Start, data and a full stop bit fit under it, so only running past that fails
    chk_frame_bound: assert property (busy |->
        busy_len < (baud_divisor + 1) * (double_speed_select ? 8 : 16) * (data_bits + 2)) else $error("long frame");
    chk_edge_start: assert property (!busy && $past(rx_line) && !rx_line |=> busy) else $error("edge missed");
    chk_no_edge: assert property (!busy && !($past(rx_line) && !rx_line) |=> !busy) else $error("false start");
    chk_start_hold: assert property ($rose(busy) && !double_speed_select |-> busy [*8]) else $error("short");
    chk_word_hold: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable(rx_data) && $stable(frame_error_flag)) else $error("word moved");
    chk_upper_zero: assert property (rx_valid |-> (rx_data >> data_bits) == '0) else $error("high bits");
    chk_ovr_held: assert property (rx_overrun |-> rx_valid) else $error("early overrun");
    chk_ovr_pulse: assert property (rx_overrun |=> !rx_overrun) else $error("long overrun");
    cover property (rx_valid && frame_error_flag);
    cover property (rx_overrun);
    cover property ($fell(busy) && double_speed_select);
endmodule
bind uadr_rx uadr_rx_asserts chk_u (.clock, .rst_n, .rx_line, .double_speed_select, .baud_divisor, .data_bits,
    .rx_data, .frame_error_flag, .rx_valid, .rx_ready, .rx_overrun, .busy);

//--- verif/uadr_tx_model.sv
`timescale 1ns/100ps
module uadr_tx_model (
    input wire logic clock,
    output logic line
);
    // ****
    // Remote sender, idle high
    // ****
    initial line = 1'b1;
    // Exact bit period keeps the rate error far inside the tolerated band
    task automatic send(input int per_bit, input int n, input logic [9:0] d, input logic stop, input int stop_len);
        line = 1'b0;
        repeat (per_bit) @(negedge clock);
        for (int i = 0; i < n; i++) begin
            line = d[i];
            repeat (per_bit) @(negedge clock);
        end
        line = stop;
        repeat (stop_len) @(negedge clock);
        line = 1'b1;
        @(negedge clock);
    endtask
endmodule

//--- verif/uadr_rx_tb.sv
`timescale 1ns/100ps
module uadr_rx_tb;
    import uadr_pkg::*;
    typedef struct packed {logic ds; logic [15:0] div; logic [3:0] bits; logic [9:0] data; logic fe;} uadr_row_t;
    // ****
    // Rows packed as the struct: both speeds, counts 5 to 10, slow ticks, bad stop
    // ****
    uadr_row_t rows [6] = '{32'h0000282a, 32'h0000d54a, 32'h80004186, 32'h800138b4, 32'h0000305b, 32'h00004bc2};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic double_speed_select = 1'b0;
    logic [15:0] baud_divisor = 16'h0;
    logic [3:0] data_bits = 4'h8;
    logic rx_ready = 1'b0;
    logic rx_line, frame_error_flag, rx_valid, rx_overrun, busy;
    logic [9:0] rx_data;
    int fail_count = 0, total_checks = 0, cycles = 0, ovr_count = 0, bit_clk;
    always #50 clock = ~clock;
    uadr_rx dut_u (.clock, .rst_n, .rx_line, .double_speed_select, .baud_divisor, .data_bits, .rx_data,
        .frame_error_flag, .rx_valid, .rx_ready, .rx_overrun, .busy);
    uadr_tx_model tx_u (.clock, .line(rx_line));
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic take(input logic [9:0] d, input logic fe);
        for (int k = 0; k < 900 && rx_valid !== 1'b1; k++) @(negedge clock);
        check({rx_valid, frame_error_flag, rx_data}, {1'b1, fe, d});
        rx_ready = 1'b1;
        @(negedge clock);
        rx_ready = 1'b0;
    endtask
    always @(posedge clock) begin
        cycles++;
        ovr_count += (rx_overrun === 1'b1);
        if (cycles == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(negedge clock);
        check({10'h0, busy, rx_valid}, 12'h0);
        rst_n = 1'b1;
        @(negedge clock);
        foreach (rows[i]) begin
            double_speed_select = rows[i].ds;
            baud_divisor = rows[i].div;
            data_bits = rows[i].bits;
            bit_clk = (rows[i].div + 1) * (rows[i].ds ? SAMPLES_DOUBLE : SAMPLES_NORMAL);
            tx_u.send(bit_clk, rows[i].bits, rows[i].data, !rows[i].fe, bit_clk);
            take(rows[i].data, rows[i].fe);
        end
        data_bits = 4'h8;
        // Glitch, then four frames with clipped stops while nobody reads
        tx_u.send(5, 0, 10'h0, 1'b1, 20);
        check({10'h0, busy, rx_valid}, 12'h0);
        for (int j = 0; j < 4; j++) tx_u.send(16, 8, 10'h041 + 10'(j), 1'b1, 11);
        for (int j = 0; j < 3; j++) take(10'h041 + 10'(j), 1'b0);
        repeat (4) @(negedge clock);
        check({rx_valid, 11'(ovr_count)}, 12'h001);
        stop_test();
    end
endmodule
